// File: battery_status_chk.sv
// port assertions for the battery status request handler
`timescale 1ns/1ps
module battery_status_chk import battery_status_pkg::*; (
	input wire logic pclk, presetn, psel, penable, pready, pslverr, setup_valid,
	input wire logic in_ready, in_valid, in_last, ep_stall, ep_ack,
	input wire logic [11:0] paddr,
	input wire logic [7:0]  setup_req_type, setup_req_code, in_data,
	input wire logic [15:0] setup_value, setup_index, setup_length
);
	logic [2:0] cnt_q;
	logic       qry;
	// counts accepted record bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt_q <= 3'd0;
		else if (in_valid && in_ready) cnt_q <= cnt_q + 3'd1;
	end
	assign qry = setup_valid && setup_req_type == REQTYPE_STATUS_QUERY
		&& setup_req_code == REQ_CODE_STATUS;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_bad_id; qry && setup_index >= NUM_BATTERIES |=> ep_stall; endproperty
	a_bad_id: assert property (p_bad_id) else $error("unknown battery not stalled");
	property p_bad_len; qry && setup_length != STATUS_LENGTH |=> ep_stall; endproperty
	a_bad_len: assert property (p_bad_len) else $error("bad length not stalled");
	property p_feat; setup_valid && setup_req_type == REQTYPE_FEATURE_SET
		&& setup_req_code == REQ_CODE_SET_FEATURE && setup_length == 0 |=> ep_ack && !in_valid;
	endproperty
	a_feat: assert property (p_feat) else $error("feature set not acked");
	property p_hold; in_valid && !in_ready |=> in_valid && $stable(in_data); endproperty
	a_hold: assert property (p_hold) else $error("byte dropped while waiting");
	property p_last; in_valid |-> in_last == (cnt_q == 3'd7); endproperty
	a_last: assert property (p_last) else $error("record not eight bytes");
	property p_end; in_valid && in_ready && in_last |=> !in_valid [*2]; endproperty
	a_end: assert property (p_end) else $error("data after last byte");
	property p_chg; in_valid && cnt_q == 3'd0 |-> in_data <= CHG_IDLE; endproperty
	a_chg: assert property (p_chg) else $error("reserved charge state");
	property p_soc; in_valid && cnt_q == 3'd1 |-> in_data <= PERCENT_MAX; endproperty
	a_soc: assert property (p_soc) else $error("charge above percent range");
	property p_cond; in_valid && cnt_q == 3'd2 |-> in_data <= COND_MAX; endproperty
	a_cond: assert property (p_cond) else $error("reserved condition code");
	property p_stall; ep_stall |=> !ep_stall && !in_valid; endproperty
	a_stall: assert property (p_stall) else $error("stall not a pulse");
	property p_unmap; psel && penable && paddr > OFF_COUNT |-> pslverr && pready; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
endmodule
bind battery_status_requests battery_status_chk i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .paddr(paddr),
	.setup_valid(setup_valid), .in_ready(in_ready), .in_valid(in_valid), .in_last(in_last),
	.ep_stall(ep_stall), .ep_ack(ep_ack), .setup_req_type(setup_req_type),
	.setup_req_code(setup_req_code), .in_data(in_data), .setup_value(setup_value),
	.setup_index(setup_index), .setup_length(setup_length));

// File: battery_status_pkg.sv
// constants, register map and types for the battery status request handler
package battery_status_pkg;
	// setup packet fields
	localparam logic [7:0]  REQTYPE_STATUS_QUERY = 8'h80; // device-to-host, standard, device
	localparam logic [7:0]  REQTYPE_FEATURE_SET  = 8'h00; // host-to-device, standard
	localparam logic [7:0]  REQ_CODE_SET_FEATURE = 8'h03;
	localparam logic [7:0]  REQ_CODE_STATUS      = 8'h15; // arbitrary default, class code
	localparam logic [15:0] STATUS_LENGTH        = 16'h0008;
	localparam int          NUM_BATTERIES        = 2;
	localparam int          RECORD_BYTES         = 8;
	// charge state codes
	localparam logic [7:0]  CHG_NONE     = 8'h00;
	localparam logic [7:0]  CHG_CHARGING = 8'h01;
	localparam logic [7:0]  CHG_DISCHG   = 8'h02;
	localparam logic [7:0]  CHG_IDLE     = 8'h03;
	// condition codes
	localparam logic [7:0]  COND_OK       = 8'h00;
	localparam logic [7:0]  COND_MISSING  = 8'h01;
	localparam logic [7:0]  COND_UNSPEC   = 8'h07;
	localparam logic [7:0]  COND_MAX      = 8'h07;
	localparam logic [7:0]  PERCENT_MAX   = 8'h64;
	// apb register offsets
	localparam logic [11:0] OFF_CTRL       = 12'h000;
	localparam logic [11:0] OFF_BAT0       = 12'h004;
	localparam logic [11:0] OFF_BAT1       = 12'h008;
	localparam logic [11:0] OFF_FEATURE    = 12'h00C;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
	localparam logic [11:0] OFF_IRQ_ENABLE = 12'h014;
	localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h018;
	localparam logic [11:0] OFF_COUNT      = 12'h01C;
	// ctrl register fields
	localparam int          CTRL_BATT_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
	// battery register field positions: [7:0] charge, [15:8] capacity, [23:16] condition
	localparam int          BAT_CHG_LSB  = 0;
	localparam int          BAT_CAP_LSB  = 8;
	localparam int          BAT_COND_LSB = 16;
	// interrupt bits
	localparam int          IRQ_QUERY   = 0;
	localparam int          IRQ_FEATURE = 1;
	localparam int          IRQ_STALL   = 2;
	localparam int          IRQ_W       = 3;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SEND  = 4'b0010,
		ST_STALL = 4'b0100,
		ST_ACK   = 4'b1000
	} ep0_state_t;
endpackage

// File: battery_status_requests.sv
// top: apb registers, interrupt logic and endpoint-zero request ports
//
// Behaviour
// - a device with a battery answers battery queries; batteries can be disabled.
// - hub bridge function lies outside this block; hub logic provides it.
// - every defined class request is handled; anything else gets a stall.
// - status query is type 80h, value zero, index battery, length eight.
// - feature set is type 00h, set-feature code, length zero, no data.
// - the record returned is that of the battery named by index.
// - each battery keeps its own record, picked by its identifier.
// - byte 0 gives charge state 0..3; reserved codes never returned.
// - byte 1 gives state of charge as a percentage.
// - byte 2 gives present battery condition when a battery is present.
// - condition codes 0..7; reserved codes mapped to unspecified.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module battery_status_requests (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        setup_valid,
	input  wire logic [7:0]  setup_req_type,
	input  wire logic [7:0]  setup_req_code,
	input  wire logic [15:0] setup_value,
	input  wire logic [15:0] setup_index,
	input  wire logic [15:0] setup_length,
	input  wire logic        in_ready,
	output logic             in_valid,
	output logic      [7:0]  in_data,
	output logic             in_last,
	output logic             ep_stall,
	output logic             ep_ack,
	output logic             irq
);
	import battery_status_pkg::*;

	typedef struct packed {
		logic [31:0]        ctrl;
		logic [23:0]        bat0;
		logic [23:0]        bat1;
		logic [IRQ_W-1:0]   irq_status;
		logic [IRQ_W-1:0]   irq_enable;
		logic [15:0]        query_count;
		logic [31:0]        rdata;
	} regs_t;

	regs_t r_q;
	regs_t r_d;
	ep0_link_if lk ();

	logic apb_acc;
	logic apb_wr;
	logic apb_rd;
	logic [IRQ_W-1:0] ev_vec;
	logic [IRQ_W-1:0] clr_vec;

	// offset decode for reads and writes
	function automatic logic mapped(input logic [11:0] a);
		case (a)
			OFF_CTRL, OFF_BAT0, OFF_BAT1, OFF_FEATURE,
			OFF_IRQ_STATUS, OFF_IRQ_ENABLE, OFF_IRQ_CLEAR, OFF_COUNT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// apb phases, zero wait states
	assign apb_acc = psel && penable;
	assign apb_wr  = apb_acc && pwrite && mapped(paddr);
	assign apb_rd  = apb_acc && !pwrite && mapped(paddr);
	assign pready  = 1'b1;
	assign pslverr = apb_acc && !mapped(paddr);
	assign prdata  = r_q.rdata;

	// engine hookup
	assign lk.setup_valid = setup_valid;
	assign lk.req_type    = setup_req_type;
	assign lk.req_code    = setup_req_code;
	assign lk.value       = setup_value;
	assign lk.index       = setup_index;
	assign lk.length      = setup_length;
	assign lk.in_ready    = in_ready;
	assign lk.batt_en     = r_q.ctrl[CTRL_BATT_EN_BIT];
	assign lk.chg[0]      = r_q.bat0[BAT_CHG_LSB +: 8];
	assign lk.soc[0]      = r_q.bat0[BAT_CAP_LSB +: 8];
	assign lk.cond[0]     = r_q.bat0[BAT_COND_LSB +: 8];
	assign lk.chg[1]      = r_q.bat1[BAT_CHG_LSB +: 8];
	assign lk.soc[1]      = r_q.bat1[BAT_CAP_LSB +: 8];
	assign lk.cond[1]     = r_q.bat1[BAT_COND_LSB +: 8];

	ep0_request_engine u_engine (
		.pclk    (pclk),
		.presetn (presetn),
		.lk      (lk)
	);

	assign in_valid = lk.in_valid;
	assign in_data  = lk.in_data;
	assign in_last  = lk.in_last;
	assign ep_stall = lk.stall;
	assign ep_ack   = lk.ack;
	assign irq      = |(r_q.irq_status & r_q.irq_enable);

	// event vector and write-one-to-clear vector
	always_comb begin
		ev_vec = '0;
		ev_vec[IRQ_QUERY]   = lk.ev_query;
		ev_vec[IRQ_FEATURE] = lk.ev_feature;
		ev_vec[IRQ_STALL]   = lk.ev_stall;
		clr_vec = (apb_wr && paddr == OFF_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : '0;
	end

	// register next values; a set on the clear cycle wins
	always_comb begin
		r_d = r_q;
		r_d.irq_status = (r_q.irq_status & ~clr_vec) | ev_vec;
		if (lk.ev_query) begin
			r_d.query_count = r_q.query_count + 16'd1;
		end
		if (apb_wr) begin
			case (paddr)
				OFF_CTRL:       r_d.ctrl = pwdata;
				OFF_BAT0:       r_d.bat0 = pwdata[23:0];
				OFF_BAT1:       r_d.bat1 = pwdata[23:0];
				OFF_IRQ_ENABLE: r_d.irq_enable = pwdata[IRQ_W-1:0];
				default:        r_d.ctrl = r_q.ctrl;
			endcase
		end
		if (apb_rd || (psel && !penable && !pwrite)) begin
			case (paddr)
				OFF_CTRL:       r_d.rdata = r_q.ctrl;
				OFF_BAT0:       r_d.rdata = {8'h00, r_q.bat0};
				OFF_BAT1:       r_d.rdata = {8'h00, r_q.bat1};
				OFF_FEATURE:    r_d.rdata = {lk.feat_idx, lk.feat_sel};
				OFF_IRQ_STATUS: r_d.rdata = {29'h0000_0000, r_q.irq_status};
				OFF_IRQ_ENABLE: r_d.rdata = {29'h0000_0000, r_q.irq_enable};
				OFF_COUNT:      r_d.rdata = {16'h0000, r_q.query_count};
				default:        r_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// register state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '{ctrl: CTRL_RESET, default: '0};
		end else begin
			r_q <= r_d;
		end
	end
endmodule

// File: battery_status_requests_tb.sv
// self-checking bench for the battery status request handler
`timescale 1ns/1ps
module battery_status_requests_tb;
	import battery_status_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, se;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, sv, ir, iv, il, es, ea, irq;
	logic [7:0]  rt, rc, dat;
	logic [15:0] vv, ix, ln;
	int          err_total = 0, num_checks = 0, seed = 85629, res, b, chg[2], soc[2], cnd[2];
	initial forever #2.5 pclk = ~pclk;
	battery_status_requests i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .setup_valid(sv), .setup_req_type(rt),
		.setup_req_code(rc), .setup_value(vv), .setup_index(ix), .setup_length(ln),
		.in_ready(ir), .in_valid(iv), .in_data(dat), .in_last(il), .ep_stall(es),
		.ep_ack(ea), .irq(irq));
	usb_host_model h (.pclk(pclk), .presetn(presetn), .slow(slow), .in_valid(iv),
		.in_last(il), .ep_stall(es), .ep_ack(ea), .in_data(dat), .setup_valid(sv),
		.in_ready(ir), .req_type(rt), .req_code(rc), .value(vv), .index(ix), .length(ln));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer: setup, access until pready, then release
	task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		se = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// reference record byte from the values loaded for battery bi
	function automatic int ref_byte(int bi, int k);
		case (k)
			0: return chg[bi] > 3 ? 3 : chg[bi];
			1: return soc[bi] > 100 ? 100 : soc[bi];
			2: return chg[bi] == 0 ? 0 : (cnd[bi] > 7 ? 7 : cnd[bi]);
			default: return 0;
		endcase
	endfunction
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFF_CTRL, 0);
		chk("ctrl", CTRL_RESET, rd);
		apb(1, OFF_IRQ_ENABLE, 32'h0000_0007);
		for (int i = 0; i < 8; i++) begin
			b = i % 2;
			slow <= i[1];
			chg[b] = $unsigned($random(seed)) % 6;
			soc[b] = $unsigned($random(seed)) % 120;
			cnd[b] = $unsigned($random(seed)) % 10;
			apb(1, b ? OFF_BAT1 : OFF_BAT0, {8'h00, 8'(cnd[b]), 8'(soc[b]), 8'(chg[b])});
			h.xfer(REQTYPE_STATUS_QUERY, REQ_CODE_STATUS, 16'h0000, 16'(b), STATUS_LENGTH, res);
			chk("query result", 0, res);
			chk("record size", 8, h.got.size());
			for (int k = 0; k < 8 && k < h.got.size(); k++)
				chk("record byte", ref_byte(b, k), h.got[k]);
		end
		chk("irq after query", 1, irq);
		apb(0, OFF_COUNT, 0);
		chk("served count", 8, rd);
		$display("test queries done");
		h.xfer(REQTYPE_STATUS_QUERY, REQ_CODE_STATUS, 16'h0000, 16'h0002, STATUS_LENGTH, res);
		chk("unknown battery", 1, res);
		h.xfer(REQTYPE_STATUS_QUERY, REQ_CODE_STATUS, 16'h0000, 16'h0000, 16'h0007, res);
		chk("short length", 1, res);
		h.xfer(REQTYPE_FEATURE_SET, REQ_CODE_SET_FEATURE, 16'h0005, 16'h00a3, 16'h0000, res);
		chk("feature ack", 2, res);
		apb(0, OFF_FEATURE, 0);
		chk("feature reg", 32'h00a3_0005, rd);
		apb(0, OFF_IRQ_STATUS, 0);
		chk("irq status", 32'h0000_0007, rd);
		apb(1, OFF_IRQ_CLEAR, 32'h0000_0007);
		@(posedge pclk); // the clear lands on the edge that ends the access
		chk("irq cleared", 0, irq);
		$display("test refusals done");
		apb(1, OFF_CTRL, 0);
		h.xfer(REQTYPE_STATUS_QUERY, REQ_CODE_STATUS, 16'h0000, 16'h0000, STATUS_LENGTH, res);
		chk("disabled battery", 1, res);
		apb(0, 12'h020, 0);
		chk("unmapped error", 1, se);
		chk("unmapped data", 0, rd);
		$display("test disable done");
		tally_and_finish();
	end
endmodule

// File: ep0_link_if.sv
// setup and data-stage signals between the register front end and the request engine
`timescale 1ns/1ps
interface ep0_link_if;
	import battery_status_pkg::*;
	logic        setup_valid;
	logic [7:0]  req_type;
	logic [7:0]  req_code;
	logic [15:0] value;
	logic [15:0] index;
	logic [15:0] length;
	logic        in_ready;
	logic        in_valid;
	logic [7:0]  in_data;
	logic        in_last;
	logic        stall;
	logic        ack;
	logic [7:0]  chg    [NUM_BATTERIES];
	logic [7:0]  soc    [NUM_BATTERIES];
	logic [7:0]  cond   [NUM_BATTERIES];
	logic        batt_en;
	logic        ev_query;
	logic        ev_feature;
	logic        ev_stall;
	logic [15:0] feat_sel;
	logic [15:0] feat_idx;
	modport front (output setup_valid, req_type, req_code, value, index, length, in_ready,
		chg, soc, cond, batt_en,
		input in_valid, in_data, in_last, stall, ack, ev_query, ev_feature, ev_stall,
		feat_sel, feat_idx);
	modport engine (input setup_valid, req_type, req_code, value, index, length, in_ready,
		chg, soc, cond, batt_en,
		output in_valid, in_data, in_last, stall, ack, ev_query, ev_feature, ev_stall,
		feat_sel, feat_idx);
endinterface

// File: ep0_request_engine.sv
// decodes control setup packets and streams the battery status record
`timescale 1ns/1ps
module ep0_request_engine (
	input  wire logic pclk,
	input  wire logic presetn,
	ep0_link_if.engine lk
);
	import battery_status_pkg::*;

	typedef struct packed {
		ep0_state_t  st;
		logic [2:0]  cnt;
		logic [63:0] rec;
		logic        ev_query;
		logic        ev_feature;
		logic        ev_stall;
		logic [15:0] feat_sel;
		logic [15:0] feat_idx;
	} eng_t;

	eng_t s_q;
	eng_t s_d;

	// never let a reserved charge state escape
	function automatic logic [7:0] clean_chg(input logic [7:0] c);
		return (c > CHG_IDLE) ? CHG_IDLE : c;
	endfunction

	// next state: decode, load record, shift bytes out
	always_comb begin
		s_d = s_q;
		s_d.ev_query = 1'b0;
		s_d.ev_feature = 1'b0;
		s_d.ev_stall = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				if (lk.setup_valid) begin
					if (lk.req_type == REQTYPE_STATUS_QUERY && lk.req_code == REQ_CODE_STATUS
						&& lk.value == 16'h0000 && lk.length == STATUS_LENGTH) begin
						// only a battery that exists is answered, others stall
						if (lk.batt_en && lk.index < 16'(NUM_BATTERIES)) begin
							// per-battery record chosen by index
							s_d.rec = '0;
							s_d.rec[7:0] = clean_chg(lk.chg[lk.index[0]]);
							s_d.rec[15:8] = (lk.soc[lk.index[0]] > PERCENT_MAX) ?
								PERCENT_MAX : lk.soc[lk.index[0]];
							s_d.rec[23:16] = (lk.chg[lk.index[0]] == CHG_NONE) ? COND_OK :
								((lk.cond[lk.index[0]] > COND_MAX) ? COND_UNSPEC :
								lk.cond[lk.index[0]]);
							s_d.cnt = '0;
							s_d.st = ST_SEND;
							s_d.ev_query = 1'b1;
						end else begin
							s_d.st = ST_STALL;
							s_d.ev_stall = 1'b1;
						end
					end else if (lk.req_type == REQTYPE_FEATURE_SET
						&& lk.req_code == REQ_CODE_SET_FEATURE && lk.length == 16'h0000) begin
						s_d.feat_sel = lk.value;
						s_d.feat_idx = lk.index;
						s_d.st = ST_ACK;
						s_d.ev_feature = 1'b1;
					end else begin
						s_d.st = ST_STALL;
						s_d.ev_stall = 1'b1;
					end
				end
			end
			ST_SEND: begin
				if (lk.in_ready) begin
					s_d.rec = {8'h00, s_q.rec[63:8]};
					s_d.cnt = s_q.cnt + 3'd1;
					if (s_q.cnt == 3'(RECORD_BYTES - 1)) begin
						s_d.st = ST_IDLE;
					end
				end
			end
			ST_STALL: s_d.st = ST_IDLE;
			ST_ACK:   s_d.st = ST_IDLE;
			default:  s_d.st = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{st: ST_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign lk.in_valid   = (s_q.st == ST_SEND);
	assign lk.in_data    = s_q.rec[7:0];
	assign lk.in_last    = (s_q.st == ST_SEND) && (s_q.cnt == 3'(RECORD_BYTES - 1));
	assign lk.stall      = (s_q.st == ST_STALL);
	assign lk.ack        = (s_q.st == ST_ACK);
	assign lk.ev_query   = s_q.ev_query;
	assign lk.ev_feature = s_q.ev_feature;
	assign lk.ev_stall   = s_q.ev_stall;
	assign lk.feat_sel   = s_q.feat_sel;
	assign lk.feat_idx   = s_q.feat_idx;
endmodule

// File: usb_host_model.sv
// host model: issues control setups and takes status bytes
`timescale 1ns/1ps
module usb_host_model (
	input  wire logic        pclk, presetn, slow, in_valid, in_last, ep_stall, ep_ack,
	input  wire logic [7:0]  in_data,
	output logic             setup_valid, in_ready,
	output logic      [7:0]  req_type, req_code,
	output logic      [15:0] value, index, length
);
	logic       tog_q;
	logic [7:0] got[$];
	initial {setup_valid, req_type, req_code, value, index, length} = '0;
	// slow mode takes a byte only every other cycle
	always_ff @(posedge pclk or negedge presetn) if (!presetn) tog_q <= 1'b0; else tog_q <= ~tog_q;
	assign in_ready = slow ? tog_q : 1'b1;
	// one setup pulse; fields scrambled after it, then wait for the answer
	task automatic xfer(input logic [7:0] t, c, input logic [15:0] v, i, l, output int res);
		res = -1;
		got = {};
		@(posedge pclk);
		setup_valid <= 1'b1;
		{req_type, req_code, value, index, length} <= {t, c, v, i, l};
		@(posedge pclk);
		setup_valid <= 1'b0;
		{req_type, req_code, value, index, length} <= ~{t, c, v, i, l};
		for (int n = 0; n < 60 && res < 0; n++) begin
			@(posedge pclk);
			// take the byte here so that the queue is complete when the task returns
			if (in_valid && in_ready) got.push_back(in_data);
			if (ep_stall) res = 1;
			else if (ep_ack) res = 2;
			else if (in_valid && in_ready && in_last) res = 0;
		end
	endtask
endmodule
